// file: rtl/pmmc_defs.vh
// Purpose: Constants for the performance monitor mode control block.
// Assumes: Included by the design files of this block only.
// Notes: Macros hold little-endian indices; in the block's own numbering bit 0 is the MSB.
`ifndef PMMC_DEFS_VH
`define PMMC_DEFS_VH

// Special-purpose register number of the mode control register.
`define PMMC_SPR_MODE_CTRL 10'h3b8
`define PMMC_REG_RESET 32'h0000_0000

// Field positions in little-endian index form (index 31 is bit 0).
`define PMMC_FREEZE_ALL 31
`define PMMC_HALT_SUP 30
`define PMMC_HALT_USER 29
`define PMMC_HALT_MARKED 28
`define PMMC_HALT_UNMARKED 27
`define PMMC_IRQ_EN 26
`define PMMC_FREEZE_ON_IRQ 25
`define PMMC_TAP_SEL_HI 24
`define PMMC_TAP_SEL_LO 23
`define PMMC_TAP_EDGE_EN 22
`define PMMC_CNT1_NEG_EN 15
`define PMMC_CNT2_NEG_EN 14
`define PMMC_CNT2_HOLD 13

// Time-base tap positions, little-endian index of a 64-bit time base.
`define PMMC_TAP_0 6'd0
`define PMMC_TAP_1 6'd8
`define PMMC_TAP_2 6'd12
`define PMMC_TAP_3 6'd16

// Sign bit of a 32-bit counter in little-endian index form.
`define PMMC_CNT_SIGN 31

`endif

// file: rtl/pmmc_tap_edge.v
// Purpose: Picks the tapped time-base bit and detects its rising edge.
// Assumes: The time base runs in the same clock domain as this logic.
// Notes: The edge pulse lasts one cycle.
`default_nettype none
`include "pmmc_defs.vh"

module pmmc_tap_edge (
    input wire clk,
    input wire rst,
    input wire [63:0] time_base,
    input wire [1:0] tap_sel,
    output wire rise
);
    reg tap_q;
    reg tap_d;

    always @* begin
        case (tap_sel)
            2'h0: tap_d = time_base[`PMMC_TAP_0];
            2'h1: tap_d = time_base[`PMMC_TAP_1];
            2'h2: tap_d = time_base[`PMMC_TAP_2];
            default: tap_d = time_base[`PMMC_TAP_3];
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_q <= 1'b0;
        end else begin
            tap_q <= tap_d;
        end
    end

    // A change of tap selection may itself look like an edge; software should
    // program the selection before enabling the edge interrupt.
    assign rise = tap_d & ~tap_q;
endmodule // pmmc_tap_edge
`default_nettype wire

// file: rtl/pmmc_inhibit.v
// Purpose: Combines every counting-inhibit condition for the two counters.
// Assumes: Privilege and mark flags are on the core clock.
// Notes: Purely combinational.
`default_nettype none
`include "pmmc_defs.vh"

module pmmc_inhibit (
    input wire [31:0] ctrl,
    input wire user_state_flag,
    input wire performance_mark_flag,
    input wire frozen_one,
    input wire frozen_two,
    output wire stop_one,
    output wire stop_two
);
    wire base_stop;

    assign base_stop = ctrl[`PMMC_FREEZE_ALL]
        | (ctrl[`PMMC_HALT_SUP] & ~user_state_flag)
        | (ctrl[`PMMC_HALT_USER] & user_state_flag)
        | (ctrl[`PMMC_HALT_MARKED] & performance_mark_flag)
        | (ctrl[`PMMC_HALT_UNMARKED] & ~performance_mark_flag);

    assign stop_one = base_stop | frozen_one;
    assign stop_two = base_stop | frozen_two;
endmodule // pmmc_inhibit
`default_nettype wire

// file: rtl/pmmc_mode_ctrl.v
// Purpose: Mode control register of the performance monitor and its gating.
// Assumes: Core drives SPR accesses and counter values on CLK; all inputs
//          come from same-domain core logic.
// Notes: Bit 0 is the most significant bit, as in the register layout.
`default_nettype none
`include "pmmc_defs.vh"

// Functional notes
// - SPR 952, 32 bits, supervisor access only.
// - Reads return contents with no side effect.
// - Freeze-all bit stops hardware counter updates.
// - Bit 1 halts counting in supervisor state.
// - Bit 2 halts counting in user state.
// - Bit 3 halts counting while marked.
// - Bit 4 halts counting while unmarked.
// - Bit 5 globally enables monitor interrupt.
// - Signalled interrupt clears the enable bit.
// - Interrupt on enabled negative counter or tap.
// - Freeze-on-interrupt stops counter one, maybe two.
// - Freeze bit clear leaves counting unchanged.
// - Two-bit field selects time-base tap bit.
// - Both counters count concurrently.
// - Bit 9 enables interrupt on tap rise.
// - Counter negative when its MSB is set.
module pmmc_mode_ctrl (
    input wire CLK,
    input wire SYS_RST,
    input wire SPR_WR,
    input wire SPR_RD,
    input wire [9:0] SPR_NUM,
    input wire [31:0] SPR_WDATA,
    input wire SUPERVISOR,
    input wire USER_STATE_FLAG,
    input wire PERFORMANCE_MARK_FLAG,
    input wire [63:0] TIME_BASE,
    input wire [31:0] EVENT_COUNTER_ONE,
    input wire [31:0] EVENT_COUNTER_TWO,
    output reg [31:0] SPR_RDATA,
    output reg SPR_HIT,
    output reg SPR_PRIV_FAULT,
    output reg [31:0] MONITOR_MODE_CONTROL,
    output reg COUNT_ONE_ALLOW,
    output reg COUNT_TWO_ALLOW,
    output reg MONITOR_IRQ
);
    reg [31:0] ctrl_q;
    reg [31:0] ctrl_d;
    reg frozen_one_q;
    reg frozen_one_d;
    reg frozen_two_q;
    reg frozen_two_d;
    wire sel;
    wire wr_ok;
    wire rd_ok;
    wire tap_rise;
    wire neg_one;
    wire neg_two;
    wire irq_cause;
    wire irq_fire;
    wire stop_one;
    wire stop_two;

    function is_negative;
        input [31:0] value;
        begin
            is_negative = value[`PMMC_CNT_SIGN];
        end
    endfunction

    assign sel = (SPR_NUM == `PMMC_SPR_MODE_CTRL);
    assign wr_ok = SPR_WR & sel & SUPERVISOR;
    assign rd_ok = SPR_RD & sel & SUPERVISOR;

    pmmc_tap_edge u_tap (
        .clk(CLK),
        .rst(SYS_RST),
        .time_base(TIME_BASE),
        .tap_sel(ctrl_q[`PMMC_TAP_SEL_HI:`PMMC_TAP_SEL_LO]),
        .rise(tap_rise)
    );

    assign neg_one = is_negative(EVENT_COUNTER_ONE);
    assign neg_two = is_negative(EVENT_COUNTER_TWO);

    assign irq_cause = (ctrl_q[`PMMC_CNT1_NEG_EN] & neg_one)
        | (ctrl_q[`PMMC_CNT2_NEG_EN] & neg_two)
        | (ctrl_q[`PMMC_TAP_EDGE_EN] & tap_rise);
    assign irq_fire = ctrl_q[`PMMC_IRQ_EN] & irq_cause;

    // The hardware clear of the enable wins over a same-cycle software write,
    // so one event never yields two interrupts.
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ok) begin
            ctrl_d = SPR_WDATA;
        end
        if (irq_fire) begin
            ctrl_d[`PMMC_IRQ_EN] = 1'b0;
        end
    end

    // Freeze holds until software rewrites the register, which restarts the
    // counting window; an event during that write still freezes.
    always @* begin
        frozen_one_d = frozen_one_q;
        frozen_two_d = frozen_two_q;
        if (wr_ok) begin
            frozen_one_d = 1'b0;
            frozen_two_d = 1'b0;
        end
        if (irq_fire && ctrl_q[`PMMC_FREEZE_ON_IRQ]) begin
            frozen_one_d = 1'b1;
            frozen_two_d = ~ctrl_q[`PMMC_CNT2_HOLD];
        end
    end

    pmmc_inhibit u_inh (
        .ctrl(ctrl_q),
        .user_state_flag(USER_STATE_FLAG),
        .performance_mark_flag(PERFORMANCE_MARK_FLAG),
        .frozen_one(frozen_one_q),
        .frozen_two(frozen_two_q),
        .stop_one(stop_one),
        .stop_two(stop_two)
    );

    always @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= `PMMC_REG_RESET;
            frozen_one_q <= 1'b0;
            frozen_two_q <= 1'b0;
            SPR_RDATA <= `PMMC_REG_RESET;
            SPR_HIT <= 1'b0;
            SPR_PRIV_FAULT <= 1'b0;
            MONITOR_MODE_CONTROL <= `PMMC_REG_RESET;
            COUNT_ONE_ALLOW <= 1'b0;
            COUNT_TWO_ALLOW <= 1'b0;
            MONITOR_IRQ <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            frozen_one_q <= frozen_one_d;
            frozen_two_q <= frozen_two_d;
            SPR_RDATA <= rd_ok ? ctrl_q : `PMMC_REG_RESET;
            SPR_HIT <= rd_ok | wr_ok;
            SPR_PRIV_FAULT <= (SPR_RD | SPR_WR) & sel & ~SUPERVISOR;
            MONITOR_MODE_CONTROL <= ctrl_d;
            // Both allows are computed independently every cycle.
            COUNT_ONE_ALLOW <= ~stop_one;
            COUNT_TWO_ALLOW <= ~stop_two;
            MONITOR_IRQ <= irq_fire;
        end
    end
endmodule // pmmc_mode_ctrl
`default_nettype wire

// file: testbench/pmmc_chk_properties.sv
// Purpose: Port-level checks for the mode control block.
// Assumes: Allows follow the register and flags by one cycle.
// Notes: Bound to every instance of the block.
`default_nettype none
module pmmc_chk (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SPR_WR,
    input wire logic SPR_RD,
    input wire logic [9:0] SPR_NUM,
    input wire logic SUPERVISOR,
    input wire logic USER_STATE_FLAG,
    input wire logic PERFORMANCE_MARK_FLAG,
    input wire logic [31:0] SPR_RDATA,
    input wire logic SPR_HIT,
    input wire logic SPR_PRIV_FAULT,
    input wire logic [31:0] MONITOR_MODE_CONTROL,
    input wire logic COUNT_ONE_ALLOW,
    input wire logic COUNT_TWO_ALLOW,
    input wire logic MONITOR_IRQ
);
    timeunit 1ns / 1ns;
    wire logic [31:0] m = MONITOR_MODE_CONTROL;
    wire logic a = COUNT_ONE_ALLOW;
    wire logic b = COUNT_TWO_ALLOW;
    wire logic u = USER_STATE_FLAG;
    wire logic k = PERFORMANCE_MARK_FLAG;
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_acc;
        (SPR_RD || SPR_WR) && SPR_NUM == 10'h3b8;
    endsequence
    AST_RD: assert property (s_acc ##0 SPR_RD && SUPERVISOR |=> SPR_HIT && SPR_RDATA == $past(m))
        else $error("read answer wrong");
    AST_PRIV: assert property (s_acc ##0 !SUPERVISOR |=> SPR_PRIV_FAULT && !SPR_HIT)
        else $error("user access not refused");
    AST_DIS: assert property (m[31] |=> !a && !b)
        else $error("counting while frozen");
    AST_SUP: assert property (m[30] && !u |=> !a)
        else $error("counting in supervisor state");
    AST_USR: assert property (m[29] && u |=> !a)
        else $error("counting in user state");
    AST_MRK: assert property (m[28] && k |=> !a)
        else $error("counting while marked");
    AST_UNM: assert property (m[27] && !k |=> !a)
        else $error("counting while unmarked");
    AST_IEN: assert property (MONITOR_IRQ |-> $past(m[26]) && !m[26])
        else $error("interrupt enable misused");
    AST_FRZ: assert property (MONITOR_IRQ && m[25] && !m[13] |=> !a && !b)
        else $error("no freeze after interrupt");
endmodule // pmmc_chk
bind pmmc_mode_ctrl pmmc_chk u_pmmc_chk (.*);
`default_nettype wire

// file: testbench/pmmc_core_model.sv
// Purpose: Core-side model supplying a free-running time base.
// Assumes: The time base advances on every core clock.
// Notes: The step lifts bits 0, 8 and 16 together, so every tap rises soon.
`default_nettype none
module pmmc_core_model (
    input wire logic clk,
    input wire logic rst,
    output logic [63:0] time_base
);
    timeunit 1ns / 1ns;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            time_base <= 64'h0;
        end else begin
            time_base <= time_base + 64'h1_0101;
        end
    end
endmodule // pmmc_core_model
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: Self-checking bench for the mode control block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: Register answers are matched against a queue of notes.
`default_nettype none
module testbench;
    timeunit 1ns / 1ns;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, sup = 1'h1, usr = 1'h0, mrk = 1'h0;
    logic hit, flt, a1, a2, irq;
    logic [9:0] num = 10'h3b8;
    logic [31:0] wd = 32'h0, c1 = 32'h0, c2 = 32'h0, rdat, mmc, c, r;
    logic [63:0] tbase;
    logic [31:0] q[$];
    int miscompares, n_tests, n;
    always #50 clk = ~clk;
    pmmc_core_model u_pmmc_core_model (.clk(clk), .rst(rst), .time_base(tbase));
    pmmc_mode_ctrl u_pmmc_mode_ctrl (.CLK(clk), .SYS_RST(rst), .SPR_WR(wr), .SPR_RD(rd),
        .SPR_NUM(num), .SPR_WDATA(wd), .SUPERVISOR(sup), .USER_STATE_FLAG(usr),
        .PERFORMANCE_MARK_FLAG(mrk), .TIME_BASE(tbase), .EVENT_COUNTER_ONE(c1),
        .EVENT_COUNTER_TWO(c2), .SPR_RDATA(rdat), .SPR_HIT(hit), .SPR_PRIV_FAULT(flt),
        .MONITOR_MODE_CONTROL(mmc), .COUNT_ONE_ALLOW(a1), .COUNT_TWO_ALLOW(a2),
        .MONITOR_IRQ(irq));
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic acc(logic w, logic [31:0] d, logic s, logic [31:0] e);
        // One idle cycle first, so a strobe is never lowered and raised at once.
        step(1);
        wr = w;
        rd = !w;
        wd = d;
        sup = s;
        if (s && num == 10'h3b8) q.push_back(e);
        step(1);
        wr = 1'h0;
        rd = 1'h0;
    endtask
    task automatic wait_irq;
        n = 0;
        while (irq !== 1'h1 && n < 64) begin
            step(1);
            n++;
        end
        chk(n < 64, 1);
        step(2);
    endtask
    task automatic end_sim;
        $display("%0d mismatches in %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // An answer with no pending note expects x, so it always mismatches.
    always @(posedge clk) begin
        if (hit === 1'h1) chk(rdat, q.size() ? q.pop_front() : 32'hx);
    end
    initial begin
        #300000;
        miscompares++;
        end_sim;
    end
    initial begin
        void'($urandom(26382));
        step(2);
        rst = 1'h0;
        acc(0, 0, 1, 0);
        acc(1, 32'h5a5a_a5a5, 1, 0);
        acc(0, 0, 1, 32'h5a5a_a5a5);
        acc(0, 0, 1, 32'h5a5a_a5a5);
        acc(1, 0, 0, 0);
        chk(flt, 1);
        num = 10'h3b9;
        acc(1, 0, 1, 0);
        num = 10'h3b8;
        acc(0, 0, 1, 32'h5a5a_a5a5);
        repeat (8) begin
            r = $urandom;
            usr = r[0];
            mrk = r[1];
            c1 = $urandom;
            c2 = $urandom;
            acc(1, {r[6:2], 27'h0}, 1, 0);
            step(2);
            n = !(r[6] | r[5] & !r[0] | r[4] & r[0] | r[3] & r[1] | r[2] & !r[1]);
            chk(a1, n);
            chk(a2, n);
        end
        for (int s = 0; s < 4; s++) begin
            c = 32'h0440_0000 | s << 23 | s[0] << 25;
            acc(1, c, 1, 0);
            wait_irq;
            chk(a1, !s[0]);
            acc(0, 0, 1, c & 32'hfbff_ffff);
        end
        c1 = 32'h7fff_ffff;
        acc(1, 32'h0600_a000, 1, 0);
        n = 0;
        repeat (8) begin
            step(1);
            n += irq;
        end
        chk(n, 0);
        c1 = 32'h8000_0000;
        wait_irq;
        chk({a1, a2}, 2'h1);
        end_sim;
    end
endmodule // testbench
`default_nettype wire
